/* testbench/adcsc_pin_model.sv */
// Analog inputs feeding the sample-hold amplifier, seen as ten-bit levels
module adcsc_pin_model (
  // Clock
  input wire logic clock_i,
  // Converter side
  input wire logic sha_connect_i,
  input wire logic conv_step_i,
  input wire logic [3:0] sel_i,
  input wire logic [15:0] ground_i,
  // Levels, ten bits per input
  input wire logic [159:0] volts_i,
  // Result toward the converter
  output logic [9:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_q;
  always_ff @(posedge clock_i) begin
    if (sha_connect_i) begin
      held_q <= ground_i[sel_i] ? 10'h000 : volts_i[sel_i*10 +: 10];
    end
  end
  // Outside a conversion the inverse shows, so a stale sample never passes for a good one
  assign result_o = conv_step_i ? held_q : ~held_q;
endmodule : adcsc_pin_model

/* testbench/adcsc_top_assertions.sv */
// Port-level checks of the scan controller, bound to its top module
`include "adcsc_regs.svh"
module adcsc_top_assertions #(
  parameter int NCH = 16,
  parameter int RES_W = 10
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Pins and analog path
  input wire logic [NCH-1:0] pin_level_i,
  input wire logic [NCH-1:0] port_read_o,
  input wire logic [NCH-1:0] mux_ground_o,
  input wire logic [3:0] mux_pos_sel_o,
  input wire logic sha_connect_o,
  input wire logic conv_step_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // Counts clocks of the running conversion; the bench keeps the divider at zero
  logic [7:0] conv_len_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_len_q <= 8'h00;
    end else if (!conv_step_o) begin
      conv_len_q <= 8'h00;
    end else if (ce_i) begin
      conv_len_q <= conv_len_q + 8'h01;
    end
  end

  sequence pin_read_s;
    rd_i && ce_i && (addr_i == `ADCSC_OFS_PINSEL || addr_i == `ADCSC_OFS_SCANMASK);
  endsequence
  sequence conv_mid_s;
    conv_step_o [*2];
  endsequence
  // Pin select held long enough for the registered read path to settle
  sequence steady_s;
    $stable(mux_ground_o) && $past(mux_ground_o, 2) == mux_ground_o;
  endsequence

  upper_zero_a: assert property (pin_read_s |=> rdata_o[31:16] == 16'h0000)
    else $error("upper half of pin or scan register not zero");
  analog_read_a: assert property (steady_s |-> &(port_read_o | mux_ground_o))
    else $error("analog pin does not read as one");
  digital_read_a: assert property (steady_s ##0 $stable(pin_level_i)
    |-> ((port_read_o ^ pin_level_i) & mux_ground_o) == 16'h0000)
    else $error("digital pin read does not follow the pin");
  acq_conv_excl_a: assert property (!(sha_connect_o && conv_step_o))
    else $error("input connected during conversion");
  conv_after_acq_a: assert property ($rose(conv_step_o) |-> $past(sha_connect_o))
    else $error("conversion started without acquisition");
  conv_len_a: assert property ($fell(conv_step_o) |-> conv_len_q inside {[8'h17:8'h19]})
    else $error("conversion length not twelve periods");
  sel_hold_a: assert property (conv_mid_s |-> $stable(mux_pos_sel_o))
    else $error("input selection moved during conversion");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(conv_step_o))
    else $error("interrupt raised outside a conversion end");
  irq_sticky_a: assert property (irq_o && !(wr_i && addr_i == `ADCSC_OFS_CTRL_TWO) |=> irq_o)
    else $error("interrupt dropped without a clear");
endmodule : adcsc_top_assertions

bind adcsc_top adcsc_top_assertions #(.NCH(NCH), .RES_W(RES_W)) u_checker (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .pin_level_i(pin_level_i), .port_read_o(port_read_o),
  .mux_ground_o(mux_ground_o), .mux_pos_sel_o(mux_pos_sel_o), .sha_connect_o(sha_connect_o),
  .conv_step_o(conv_step_o), .irq_o(irq_o)
);

/* testbench/adcsc_top_tb.sv */
// Self-checking bench of the scan controller with its analog pin model
`include "adcsc_regs.svh"
`define check(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module adcsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ON = 32'h0000_8000;
  localparam logic [31:0] AUTO_STOP = 32'h0000_8014;
  logic clock_i, arst_n_i, ce_i, wr_i, rd_i, timer_three_match_i, external_int_pin_0_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [15:0] pin_level_i, port_read_o, mux_ground_o, pin_sel, mask;
  logic [3:0] mux_pos_sel_o;
  logic sha_connect_o, conv_step_o, irq_o;
  logic [9:0] sar_result_i;
  logic [159:0] volts;
  int n_mismatch, num_checks, cycles, seed, n;

  adcsc_top uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_three_match_i(timer_three_match_i), .external_int_pin_0_i(external_int_pin_0_i),
    .pin_level_i(pin_level_i), .port_read_o(port_read_o), .mux_ground_o(mux_ground_o),
    .mux_pos_sel_o(mux_pos_sel_o), .sha_connect_o(sha_connect_o), .conv_step_o(conv_step_o),
    .sar_result_i(sar_result_i), .irq_o(irq_o));
  adcsc_pin_model u_pins (.clock_i(clock_i), .sha_connect_i(sha_connect_o),
    .conv_step_i(conv_step_o), .sel_i(mux_pos_sel_o), .ground_i(mux_ground_o),
    .volts_i(volts), .result_o(sar_result_i));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [9:0] exp_res(input logic [3:0] c);
    return pin_sel[c] ? 10'h000 : volts[c*10 +: 10];
  endfunction : exp_res
  function automatic logic in_scan(input logic [9:0] v);
    in_scan = 1'b0;
    for (int c = 0; c < 16; c++) begin
      if (mask[c] && exp_res(4'(c)) == v) in_scan = 1'b1;
    end
  endfunction : in_scan

  // Each access waits an edge first, so a strobe is never set and cleared in one step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_reg
  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq_o !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    `check("irq", 1'b1, irq_o)
  endtask : wait_irq
  task automatic clr_irq();
    wr_reg(`ADCSC_OFS_CTRL_TWO, 32'h0000_0000);
    #1 `check("irq clear", 1'b0, irq_o)
  endtask : clr_irq
  task automatic arm(input logic [31:0] two, input logic [31:0] sel, input logic [31:0] one);
    wr_reg(`ADCSC_OFS_CTRL_ONE, 32'h0000_0000);
    wr_reg(`ADCSC_OFS_INSEL, sel);
    wr_reg(`ADCSC_OFS_CTRL_TWO, two);
    wr_reg(`ADCSC_OFS_CTRL_ONE, one);
  endtask : arm
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    seed = 28829;
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    timer_three_match_i = 1'b0;
    external_int_pin_0_i = 1'b0;
    pin_level_i = 16'h0000;
    for (int c = 0; c < 16; c++) volts[c*10 +: 10] = {4'(c), 6'($random(seed))};
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    // Reset words, the last address unmapped
    for (int i = 0; i < 28; i += 4) begin
      rd_reg(8'(i));
      `check("reset word", 32'h0000_0000, d)
    end
    for (int k = 0; k < 5; k++) begin
      wr_reg(`ADCSC_OFS_PINSEL, k == 4 ? 32'hFFFF_00F0 : $random(seed));
      rd_reg(`ADCSC_OFS_PINSEL);
      pin_sel = d[15:0];
      `check("pin select high", 16'h0000, d[31:16])
      wr_reg(`ADCSC_OFS_SCANMASK, $random(seed));
      rd_reg(`ADCSC_OFS_SCANMASK);
      `check("scan mask high", 16'h0000, d[31:16])
      pin_level_i <= 16'($random(seed));
      repeat (4) @(posedge clock_i);
      #1 `check("ground", pin_sel, mux_ground_o)
      `check("port read", pin_level_i | ~pin_sel, port_read_o)
    end
    `check("pin select kept", 16'h00F0, pin_sel)
    wr_reg(`ADCSC_OFS_CTRL_THREE, 32'h0000_0300);
    // Manual sampling, ended by software; input 5 is grounded
    for (int k = 3; k < 6; k += 2) begin
      arm(32'h0000_0000, 32'(k) << 16, ON | 32'h0000_0002);
      repeat (20) @(posedge clock_i);
      #1 `check("acquiring", 2'b10, {sha_connect_o, conv_step_o})
      `check("input select", 4'(k), mux_pos_sel_o)
      wr_reg(`ADCSC_OFS_CTRL_ONE, ON);
      wait_irq();
      rd_reg(`ADCSC_OFS_RESULT_BASE);
      `check("manual result", exp_res(4'(k)), d[9:0])
      rd_reg(`ADCSC_OFS_CTRL_ONE);
      `check("done", 2'b01, d[1:0])
      clr_irq();
    end
    // Hardware triggers: external edge, then timer match
    for (int t = 1; t < 3; t++) begin
      arm(32'h0000_0000, 32'(8 + t) << 16, AUTO_STOP | 32'(t) << 5);
      repeat (60) @(posedge clock_i);
      #1 `check("no trigger", 1'b0, conv_step_o | irq_o)
      timer_three_match_i <= (t == 2);
      external_int_pin_0_i <= (t == 1);
      @(posedge clock_i);
      timer_three_match_i <= 1'b0;
      wait_irq();
      external_int_pin_0_i <= 1'b0;
      rd_reg(`ADCSC_OFS_RESULT_BASE);
      `check("trigger result", exp_res(4'(8 + t)), d[9:0])
      rd_reg(`ADCSC_OFS_CTRL_ONE);
      `check("auto start cleared", 1'b0, d[2])
      clr_irq();
    end
    // Free-running scan with the internal counter, stopped by the first interrupt
    mask = 16'($random(seed)) | 16'h0011;
    n = $countones(mask);
    wr_reg(`ADCSC_OFS_SCANMASK, {16'h0000, mask});
    arm(32'h0000_0400 | 32'(n - 1) << 2, 32'h0000_0000, AUTO_STOP | 32'h0000_00E0);
    wait_irq();
    for (int i = 0; i < n; i++) begin
      rd_reg(8'h40 + 8'(4 * i));
      `check("scan result", 1'b1, in_scan(d[9:0]))
    end
    repeat (100) @(posedge clock_i);
    #1 `check("stopped", 1'b0, conv_step_o | sha_connect_o)
    clr_irq();
    // Alternating selections refill from the first entry
    arm(32'h0000_0005, 32'h0A02_0000, AUTO_STOP | 32'h0000_00E0);
    wait_irq();
    rd_reg(`ADCSC_OFS_RESULT_BASE);
    `check("alternate first", exp_res(4'h2), d[9:0])
    rd_reg(8'h44);
    `check("alternate second", exp_res(4'hA), d[9:0])
    clr_irq();
    end_of_test();
  end
endmodule : adcsc_top_tb

/* verilog/adcsc_pkg.sv */
// Types shared by the scan controller modules
package adcsc_pkg;

  typedef enum logic [1:0] {
    ADCSC_IDLE = 2'b00,
    ADCSC_ACQ = 2'b01,
    ADCSC_CONV = 2'b10
  } adcsc_state_t;

  typedef enum logic [2:0] {
    ADCSC_TRIG_SW = 3'b000,
    ADCSC_TRIG_EXT = 3'b001,
    ADCSC_TRIG_TMR = 3'b010,
    ADCSC_TRIG_AUTO = 3'b111
  } adcsc_trig_t;

endpackage : adcsc_pkg

/* verilog/adcsc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the scan controller
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define ADCSC_OFS_CTRL_ONE 8'h00
`define ADCSC_OFS_CTRL_TWO 8'h04
`define ADCSC_OFS_CTRL_THREE 8'h08
`define ADCSC_OFS_INSEL 8'h0C
`define ADCSC_OFS_PINSEL 8'h10
`define ADCSC_OFS_SCANMASK 8'h14
`define ADCSC_OFS_RESULT_BASE 8'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCSC_C1_DONE 0
`define ADCSC_C1_SAMPLE_ACTIVE 1
`define ADCSC_C1_AUTO_SAMPLE_START 2
`define ADCSC_C1_STOP_ON_FIRST_IRQ 4
`define ADCSC_C1_TRIGGER_SOURCE_SEL_LO 5
`define ADCSC_C1_TRIGGER_SOURCE_SEL_HI 7
`define ADCSC_C1_ON 15
`define ADCSC_C2_ALTS 0
`define ADCSC_C2_SEQUENCES_PER_IRQ_LO 2
`define ADCSC_C2_SEQUENCES_PER_IRQ_HI 5
`define ADCSC_C2_CSCNA 10
`define ADCSC_C2_IRQ 7
`define ADCSC_C3_CDIV_LO 0
`define ADCSC_C3_CDIV_HI 7
`define ADCSC_C3_SAMPLE_TIME_COUNT_LO 8
`define ADCSC_C3_SAMPLE_TIME_COUNT_HI 12
`define ADCSC_IS_SA_LO 16
`define ADCSC_IS_SA_HI 19
`define ADCSC_IS_SB_LO 24
`define ADCSC_IS_SB_HI 27

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define ADCSC_RST_WORD 32'h0000_0000
`define ADCSC_CONV_PERIODS 4'hC
`define ADCSC_MASK_LOW16 32'h0000_FFFF

`endif

/* verilog/adcsc_result_buf.sv */
// Sixteen-entry conversion result store
module adcsc_result_buf #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Write side
  input wire logic wr_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read side
  input wire logic [3:0] rd_idx_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        mem_q[g] <= '0;
      end else if (ce_i && wr_i && (wr_idx_i == 4'(g))) begin
        mem_q[g] <= wr_data_i;
      end
    end
  end

  assign rd_data_o = mem_q[rd_idx_i];
endmodule : adcsc_result_buf

/* verilog/adcsc_tick.sv */
// Conversion clock period tick generator
module adcsc_tick (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Control
  input wire logic run_i,
  input wire logic [7:0] div_i,
  // Tick out
  output logic tick_o
);
  logic [8:0] cnt_q;
  logic [8:0] limit;
  logic hit;

  // One tick every 2*(div+1) bus clocks
  assign limit = {div_i, 1'b1};
  assign hit = (cnt_q == limit);
  assign tick_o = run_i & hit;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 9'h000;
    end else if (ce_i) begin
      cnt_q <= (!run_i || hit) ? 9'h000 : cnt_q + 9'h001;
    end
  end
endmodule : adcsc_tick

/* verilog/adcsc_top.sv */
// Acquisition, conversion and scan sequencing of the 10-bit converter
//
// Overview of operation
// - Pin select bit 1: pin digital, port read live, converter input tied to ground.
// - Pin select bit 0: pin analog, port read returns 1, converter samples it.
// - Upper sixteen bits of pin select and scan mask read as zero.
// - Scan includes input n only when scan mask bit n is set; the first scan after reset converts input 0 whatever the mask.
// - Each sample is acquisition with input connected, then hold and convert.
// - Two input selections, A and B, optionally alternating between conversions.
// - Scan mode steps through inputs using selection A only; here the scanned input also replaces B, so no alternation while scanning.
// - Automatic acquisition is started by hardware; length from sample_time_count only with the 111 counter trigger.
// - Conversion lasts twelve conversion clock periods.
// - Each finished conversion is written into one of sixteen result entries.
// - With auto_sample_start, acquisition restarts right after each conversion.
// - Selected trigger ends acquisition and starts conversion, hardware or software.
// - Auto-convert trigger counts acquisition in conversion clock periods.
// - Auto start plus auto-convert repeats sequences without software.
// - Interrupt after sequences_per_irq plus one sequences, one to sixteen.
// - Each new interrupt sequence fills the result store from its first entry.
// - Trigger codes: 111 counter, 010 timer, 001 external edge, 000 software.
// - In automatic modes done clears when acquisition starts from idle; a restart right after a conversion leaves it set.
// - stop_on_first_irq clears auto_sample_start when the interrupt is raised.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "adcsc_regs.svh"
module adcsc_top #(
  parameter int NCH = 16,
  parameter int RES_W = 10
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Trigger sources
  input wire logic timer_three_match_i,
  input wire logic external_int_pin_0_i,
  // Pins and analog path
  input wire logic [NCH-1:0] pin_level_i,
  output logic [NCH-1:0] port_read_o,
  output logic [NCH-1:0] mux_ground_o,
  output logic [3:0] mux_pos_sel_o,
  output logic sha_connect_o,
  output logic conv_step_o,
  input wire logic [RES_W-1:0] sar_result_i,
  // Interrupt request
  output logic irq_o
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic on_q, sample_active_q, auto_sample_start_q, stop_on_first_irq_q, done_q, alts_q, cscna_q, irq_q;
  logic [2:0] trigger_source_sel_q;
  logic [3:0] sequences_per_irq_q;
  logic [4:0] sample_time_count_q;
  logic [7:0] cdiv_q;
  logic [3:0] sa_q, sb_q;
  logic [15:0] pinsel_q, scanmask_q;
  adcsc_pkg::adcsc_state_t state_q, state_d;
  logic [4:0] tcnt_q;
  logic use_b_q;
  logic [3:0] scan_q;
  logic [3:0] wptr_q, seq_q;
  logic ext_q;
  logic [31:0] rdata_q;
  logic [NCH-1:0] port_q, gnd_q;
  logic [3:0] pos_q;
  logic sha_q;
  logic conv_q;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire wr_c1 = wr_i && (addr_i == `ADCSC_OFS_CTRL_ONE);
  wire wr_c2 = wr_i && (addr_i == `ADCSC_OFS_CTRL_TWO);
  wire wr_c3 = wr_i && (addr_i == `ADCSC_OFS_CTRL_THREE);
  wire wr_is = wr_i && (addr_i == `ADCSC_OFS_INSEL);
  wire wr_ps = wr_i && (addr_i == `ADCSC_OFS_PINSEL);
  wire wr_sm = wr_i && (addr_i == `ADCSC_OFS_SCANMASK);
  wire rd_res = (addr_i[7:6] == 2'b01);
  wire sample_active_wr_clr = wr_c1 && sample_active_q && !wdata_i[`ADCSC_C1_SAMPLE_ACTIVE];
  wire sample_active_wr_set = wr_c1 && wdata_i[`ADCSC_C1_SAMPLE_ACTIVE];

  // ****************************************************************
  // Tick and trigger
  // ****************************************************************
  logic tick;
  adcsc_tick u_tick (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .run_i(on_q && (state_q != adcsc_pkg::ADCSC_IDLE)),
    .div_i(cdiv_q),
    .tick_o(tick)
  );

  wire ext_edge = external_int_pin_0_i && !ext_q;
  wire in_acq = (state_q == adcsc_pkg::ADCSC_ACQ);
  wire in_conv = (state_q == adcsc_pkg::ADCSC_CONV);
  logic trig;
  always_comb begin
    unique case (trigger_source_sel_q)
      adcsc_pkg::ADCSC_TRIG_SW: trig = sample_active_wr_clr;
      adcsc_pkg::ADCSC_TRIG_EXT: trig = ext_edge;
      adcsc_pkg::ADCSC_TRIG_TMR: trig = timer_three_match_i;
      adcsc_pkg::ADCSC_TRIG_AUTO: trig = tick && (tcnt_q + 5'h01 >= sample_time_count_q);
      default: trig = 1'b0;
    endcase
  end

  wire conv_end = in_conv && tick && (tcnt_q == 5'(`ADCSC_CONV_PERIODS - 1));
  wire seq_last = (seq_q == sequences_per_irq_q);
  wire raise_irq = conv_end && seq_last;
  wire auto_sample_start_eff = auto_sample_start_q && !(raise_irq && stop_on_first_irq_q);
  // A sampling bit written together with the enable must still start acquisition
  wire idle_go = (state_q == adcsc_pkg::ADCSC_IDLE) && (sample_active_wr_set || sample_active_q || auto_sample_start_q);
  wire start_acq = on_q && (idle_go || (conv_end && auto_sample_start_eff));

  // Next scan input: lowest masked index above current, wrapping
  logic [3:0] scan_next;
  always_comb begin
    scan_next = scan_q;
    for (int k = 16; k >= 1; k--) begin
      if (scanmask_q[4'(scan_q + 4'(k))]) begin
        scan_next = 4'(scan_q + 4'(k));
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adcsc_pkg::ADCSC_IDLE: if (start_acq) state_d = adcsc_pkg::ADCSC_ACQ;
      adcsc_pkg::ADCSC_ACQ: if (trig) state_d = adcsc_pkg::ADCSC_CONV;
      adcsc_pkg::ADCSC_CONV: begin
        if (conv_end) state_d = auto_sample_start_eff ? adcsc_pkg::ADCSC_ACQ : adcsc_pkg::ADCSC_IDLE;
      end
      default: state_d = adcsc_pkg::ADCSC_IDLE;
    endcase
    if (!on_q) state_d = adcsc_pkg::ADCSC_IDLE;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= adcsc_pkg::ADCSC_IDLE;
      tcnt_q <= 5'h00;
      ext_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      ext_q <= external_int_pin_0_i;
      if (state_d != state_q) tcnt_q <= 5'h00;
      else if (tick) tcnt_q <= tcnt_q + 5'h01;
    end
  end

  // Input selection, pointers, sequence count
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      use_b_q <= 1'b0;
      scan_q <= 4'h0;
      wptr_q <= 4'h0;
      seq_q <= 4'h0;
    end else if (ce_i) begin
      if (conv_end) begin
        use_b_q <= alts_q && !use_b_q;
        if (cscna_q) scan_q <= scan_next;
        wptr_q <= raise_irq ? 4'h0 : wptr_q + 4'h1;
        seq_q <= seq_last ? 4'h0 : seq_q + 4'h1;
      end
    end
  end

  logic [RES_W-1:0] res_rd;
  adcsc_result_buf #(.DEPTH(16), .WIDTH(RES_W)) u_buf (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .wr_i(conv_end),
    .wr_idx_i(wptr_q),
    .wr_data_i(sar_result_i),
    .rd_idx_i(addr_i[5:2]),
    .rd_data_o(res_rd)
  );

  // ****************************************************************
  // Control register state
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      on_q <= 1'b0;
      sample_active_q <= 1'b0;
      auto_sample_start_q <= 1'b0;
      stop_on_first_irq_q <= 1'b0;
      done_q <= 1'b0;
      alts_q <= 1'b0;
      cscna_q <= 1'b0;
      irq_q <= 1'b0;
      trigger_source_sel_q <= 3'h0;
      sequences_per_irq_q <= 4'h0;
      sample_time_count_q <= 5'h00;
      cdiv_q <= 8'h00;
      sa_q <= 4'h0;
      sb_q <= 4'h0;
      pinsel_q <= 16'h0000;
      scanmask_q <= 16'h0000;
    end else if (ce_i) begin
      if (wr_c1) begin
        on_q <= wdata_i[`ADCSC_C1_ON];
        trigger_source_sel_q <= wdata_i[`ADCSC_C1_TRIGGER_SOURCE_SEL_HI:`ADCSC_C1_TRIGGER_SOURCE_SEL_LO];
        stop_on_first_irq_q <= wdata_i[`ADCSC_C1_STOP_ON_FIRST_IRQ];
      end
      if (wr_c1) auto_sample_start_q <= wdata_i[`ADCSC_C1_AUTO_SAMPLE_START];
      else if (raise_irq && stop_on_first_irq_q) auto_sample_start_q <= 1'b0;
      // Sampling flag mirrors acquisition; hardware set wins
      if (start_acq || (in_acq && !trig)) sample_active_q <= 1'b1;
      else if (wr_c1) sample_active_q <= wdata_i[`ADCSC_C1_SAMPLE_ACTIVE];
      else if (trig && in_acq) sample_active_q <= 1'b0;
      if (conv_end) done_q <= 1'b1;
      else if (start_acq && auto_sample_start_q) done_q <= 1'b0;
      else if (wr_c1) done_q <= wdata_i[`ADCSC_C1_DONE];
      if (raise_irq) irq_q <= 1'b1;
      else if (wr_c2) irq_q <= wdata_i[`ADCSC_C2_IRQ];
      if (wr_c2) begin
        alts_q <= wdata_i[`ADCSC_C2_ALTS];
        sequences_per_irq_q <= wdata_i[`ADCSC_C2_SEQUENCES_PER_IRQ_HI:`ADCSC_C2_SEQUENCES_PER_IRQ_LO];
        cscna_q <= wdata_i[`ADCSC_C2_CSCNA];
      end
      if (wr_c3) begin
        cdiv_q <= wdata_i[`ADCSC_C3_CDIV_HI:`ADCSC_C3_CDIV_LO];
        sample_time_count_q <= wdata_i[`ADCSC_C3_SAMPLE_TIME_COUNT_HI:`ADCSC_C3_SAMPLE_TIME_COUNT_LO];
      end
      if (wr_is) begin
        sa_q <= wdata_i[`ADCSC_IS_SA_HI:`ADCSC_IS_SA_LO];
        sb_q <= wdata_i[`ADCSC_IS_SB_HI:`ADCSC_IS_SB_LO];
      end
      if (wr_ps) pinsel_q <= wdata_i[15:0];
      if (wr_sm) scanmask_q <= wdata_i[15:0];
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `ADCSC_RST_WORD;
    unique case (addr_i)
      `ADCSC_OFS_CTRL_ONE: begin
        rd_mux[`ADCSC_C1_ON] = on_q;
        rd_mux[`ADCSC_C1_TRIGGER_SOURCE_SEL_HI:`ADCSC_C1_TRIGGER_SOURCE_SEL_LO] = trigger_source_sel_q;
        rd_mux[`ADCSC_C1_STOP_ON_FIRST_IRQ] = stop_on_first_irq_q;
        rd_mux[`ADCSC_C1_AUTO_SAMPLE_START] = auto_sample_start_q;
        rd_mux[`ADCSC_C1_SAMPLE_ACTIVE] = sample_active_q;
        rd_mux[`ADCSC_C1_DONE] = done_q;
      end
      `ADCSC_OFS_CTRL_TWO: begin
        rd_mux[`ADCSC_C2_CSCNA] = cscna_q;
        rd_mux[`ADCSC_C2_IRQ] = irq_q;
        rd_mux[`ADCSC_C2_SEQUENCES_PER_IRQ_HI:`ADCSC_C2_SEQUENCES_PER_IRQ_LO] = sequences_per_irq_q;
        rd_mux[`ADCSC_C2_ALTS] = alts_q;
      end
      `ADCSC_OFS_CTRL_THREE: begin
        rd_mux[`ADCSC_C3_SAMPLE_TIME_COUNT_HI:`ADCSC_C3_SAMPLE_TIME_COUNT_LO] = sample_time_count_q;
        rd_mux[`ADCSC_C3_CDIV_HI:`ADCSC_C3_CDIV_LO] = cdiv_q;
      end
      `ADCSC_OFS_INSEL: begin
        rd_mux[`ADCSC_IS_SA_HI:`ADCSC_IS_SA_LO] = sa_q;
        rd_mux[`ADCSC_IS_SB_HI:`ADCSC_IS_SB_LO] = sb_q;
      end
      `ADCSC_OFS_PINSEL: rd_mux[15:0] = pinsel_q;
      `ADCSC_OFS_SCANMASK: rd_mux[15:0] = scanmask_q;
      default: if (rd_res) rd_mux[RES_W-1:0] = res_rd;
    endcase
  end

  // ****************************************************************
  // Outputs, all registered
  // ****************************************************************
  wire [3:0] pos_d = cscna_q ? scan_q : (use_b_q ? sb_q : sa_q);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= `ADCSC_RST_WORD;
      port_q <= '1;
      gnd_q <= '0;
      pos_q <= 4'h0;
      sha_q <= 1'b0;
      conv_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= rd_i ? rd_mux : `ADCSC_RST_WORD;
      port_q <= pin_level_i | ~pinsel_q;
      gnd_q <= pinsel_q;
      pos_q <= pos_d;
      sha_q <= (state_d == adcsc_pkg::ADCSC_ACQ);
      conv_q <= (state_d == adcsc_pkg::ADCSC_CONV);
    end
  end

  assign rdata_o = rdata_q;
  assign port_read_o = port_q;
  assign mux_ground_o = gnd_q;
  assign mux_pos_sel_o = pos_q;
  assign sha_connect_o = sha_q;
  assign conv_step_o = conv_q;
  assign irq_o = irq_q;
endmodule : adcsc_top
